// file: rtl/rdfp_pkg.sv
// shared constants and types for the radio data fifo pair
package rdfp_pkg;
   ////////////////////////////////////////////////////////////////////////
   // fifo geometry
   localparam int DATA_W     = 8;   // byte lanes
   localparam int FIFO_DEPTH = 64;  // bytes per fifo
   localparam int CNT_W      = 7;   // count 0..64
   ////////////////////////////////////////////////////////////////////////
   // link frame layout, in sclk rising edges
   localparam logic [5:0] HDR_LEN    = 6'h08; // header edges
   localparam logic [5:0] GAP_BITS   = 6'h08; // read turnaround edges
   localparam logic [5:0] WR_LEN     = 6'h10; // header plus write byte
   localparam logic [5:0] RD_LEN     = 6'h18; // header, gap, read byte
   localparam logic [5:0] RD_LOAD    = 6'h10; // edge that shows read data
   localparam int         HDR_RD_BIT = 7;     // header: 1 = read
   localparam int         HDR_ST_BIT = 6;     // header: 1 = status only
   ////////////////////////////////////////////////////////////////////////
   // threshold coding
   localparam logic [CNT_W-1:0] RX_THR_STEP = 7'h04; // rx step and base
   localparam logic [CNT_W-1:0] TX_THR_BASE = 7'h3D; // tx threshold at 0
   ////////////////////////////////////////////////////////////////////////
   // output pin source codes
   localparam logic [1:0] PIN_RX_THR = 2'h0; // rx threshold flag
   localparam logic [1:0] PIN_TX_THR = 2'h1; // tx threshold flag
   localparam logic [1:0] PIN_RX_OVF = 2'h2; // rx overflow flag
   localparam logic [1:0] PIN_TX_UNF = 2'h3; // tx underflow flag
   ////////////////////////////////////////////////////////////////////////
   // host link engine
   localparam logic [1:0] SCLK_HALF = 2'h3; // clk cycles per half, minus 1
   localparam logic [1:0] END_SPACE = 2'h1; // idle sclk periods, minus 1
   typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_SPACE} rdfp_host_e;
   ////////////////////////////////////////////////////////////////////////
   // gray helpers for the fill count crossing
   function automatic logic [CNT_W-1:0] rdfp_bin2gray(
      input logic [CNT_W-1:0] b);
      return b ^ (b >> 1);
   endfunction : rdfp_bin2gray

   function automatic logic [CNT_W-1:0] rdfp_gray2bin(
      input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b = '0;
      for (int i = CNT_W - 1; i >= 0; i--) begin
         b[i] = g[i] ^ ((i == CNT_W - 1) ? 1'b0 : b[i + 1]);
      end
      return b;
   endfunction : rdfp_gray2bin
endpackage : rdfp_pkg

// file: rtl/rdfp_link_if.sv
// serial link between the host end and the device end
`timescale 1ns/1ns
`default_nettype none
interface rdfp_link_if;
   logic sclk;  // link clock, made by the host
   logic csN;   // frame select, active low
   logic mosi;  // host to device data
   logic miso;  // device to host data
   modport host (output sclk, output csN, output mosi, input miso);
   modport dev  (input sclk, input csN, input mosi, output miso);
endinterface : rdfp_link_if
`default_nettype wire

// file: rtl/rdfp_fifo.sv
// byte fifo with valid/ready on both sides and a fill count
`timescale 1ns/1ns
`default_nettype none
module rdfp_fifo #(
   parameter int WIDTH = 8,   // data width
   parameter int DEPTH = 64   // entries
) (
   input  wire logic                       clk,      // core clock
   input  wire logic                       rst,      // sync reset
   input  wire logic [WIDTH-1:0]           inData,   // write data
   input  wire logic                       inValid,  // write request
   output logic                            inReady,  // not full
   output logic [WIDTH-1:0]                outData,  // head entry
   output logic                            outValid, // not empty
   input  wire logic                       outReady, // read request
   output logic [$clog2(DEPTH+1)-1:0]      count     // entries held
);
   localparam int PW = $clog2(DEPTH);   // pointer width
   localparam int CW = $clog2(DEPTH+1); // count width

   logic [WIDTH-1:0] mem [DEPTH];  // storage
   logic [PW-1:0]    wrPtr_r;      // next write slot
   logic [PW-1:0]    rdPtr_r;      // head slot
   logic [CW-1:0]    count_r;      // fill level

   wire doPush = inValid && inReady;    // accepted write
   wire doPop  = outReady && outValid;  // accepted read

   assign inReady  = count_r != CW'(DEPTH);
   assign outValid = count_r != '0;
   assign outData  = mem[rdPtr_r];
   assign count    = count_r;

   ////////////////////////////////////////////////////////////////////////
   // storage write, no reset needed
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_r] <= inData;
      end
   end

   // pointers and level
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         wrPtr_r <= doPush ? PW'(wrPtr_r + 1'b1) : wrPtr_r;
         rdPtr_r <= doPop ? PW'(rdPtr_r + 1'b1) : rdPtr_r;
         count_r <= CW'(count_r + doPush - doPop);
      end
   end
endmodule : rdfp_fifo
`default_nettype wire

// file: rtl/rdfp_host.sv
// host end: link engine that frames status, read and write accesses
`timescale 1ns/1ns
`default_nettype none
module rdfp_host
   import rdfp_pkg::*;
(
   input  wire logic        clk,           // core clock
   input  wire logic        rst,           // sync reset
   rdfp_link_if.host        link,          // serial link
   input  wire logic        cmdValid,      // access request
   output logic             cmdReady,      // request taken
   input  wire logic        cmdRead,       // 1 = read rx byte
   input  wire logic        cmdStatusOnly, // 1 = fill poll only
   input  wire logic [7:0]  cmdData,       // byte for tx fifo
   output logic             respValid,     // access done, pulse
   output logic [7:0]       respStatus,    // fill level seen
   output logic [7:0]       respData       // rx byte read
);
   rdfp_host_e  state_r;     // engine state
   logic [1:0]  divCnt_r;    // sclk divider
   logic        sclk_r;      // link clock
   logic        csN_r;       // frame select
   logic        mosi_r;      // outgoing bit
   logic [15:0] txSh_r;      // header and data out
   logic [5:0]  edgeCnt_r;   // rising edges in frame
   logic [5:0]  frameLen_r;  // edges in this frame
   logic        isRead_r;    // read frame
   logic [6:0]  statSh_r;    // status bits in
   logic [7:0]  dataSh_r;    // data bits in
   logic [1:0]  spaceCnt_r;  // gap after frame
   logic        respValid_r; // done pulse
   logic        misoS1_r;    // miso sync first
   logic        misoS2_r;    // miso sync second

   ////////////////////////////////////////////////////////////////////////
   // decode
   wire tick    = divCnt_r == SCLK_HALF;   // sclk about to change
   wire riseNow = tick && !sclk_r;         // rising edge next
   wire fallNow = tick && sclk_r;          // falling edge next
   wire [7:0] hdr = {cmdRead, cmdStatusOnly, 6'h00};
   wire [5:0] lenSel = cmdStatusOnly ? HDR_LEN : (cmdRead ? RD_LEN : WR_LEN);
   wire inStat = edgeCnt_r != 6'h00 && edgeCnt_r < HDR_LEN;
   wire inData = isRead_r && edgeCnt_r >= RD_LOAD && edgeCnt_r < RD_LEN;
   wire lastEdge = edgeCnt_r == frameLen_r;

   assign cmdReady   = state_r == HS_IDLE && fallNow;
   assign link.sclk  = sclk_r;
   assign link.csN   = csN_r;
   assign link.mosi  = mosi_r;
   assign respValid  = respValid_r;
   assign respStatus = {1'b0, statSh_r};
   assign respData   = dataSh_r;

   ////////////////////////////////////////////////////////////////////////
   // free running link clock divider
   always_ff @(posedge clk) begin
      if (rst) begin
         divCnt_r <= 2'h0;
         sclk_r   <= 1'b0;
      end else begin
         divCnt_r <= tick ? 2'h0 : 2'(divCnt_r + 1'b1);
         sclk_r   <= tick ? !sclk_r : sclk_r;
      end
   end

   // miso is from the link clock domain
   always_ff @(posedge clk) begin
      misoS1_r <= link.miso;
      misoS2_r <= misoS1_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // frame engine
   always_ff @(posedge clk) begin
      respValid_r <= 1'b0;
      if (rst) begin
         state_r    <= HS_IDLE;
         csN_r      <= 1'b1;
         mosi_r     <= 1'b0;
         txSh_r     <= 16'h0000;
         edgeCnt_r  <= 6'h00;
         frameLen_r <= 6'h00;
         isRead_r   <= 1'b0;
         statSh_r   <= 7'h00;
         dataSh_r   <= 8'h00;
         spaceCnt_r <= 2'h0;
      end else begin
         case (state_r)
            HS_IDLE: begin
               if (cmdValid && cmdReady) begin
                  txSh_r     <= {hdr, cmdRead ? 8'h00 : cmdData};
                  mosi_r     <= hdr[7];
                  frameLen_r <= lenSel;
                  isRead_r   <= cmdRead && !cmdStatusOnly;
                  edgeCnt_r  <= 6'h00;
                  csN_r      <= 1'b0;
                  state_r    <= HS_SHIFT;
               end
            end
            HS_SHIFT: begin
               if (riseNow) begin
                  edgeCnt_r <= 6'(edgeCnt_r + 1'b1);
               end else if (fallNow && edgeCnt_r != 6'h00) begin
                  // status gives the level that guards
                  if (inStat) begin
                     statSh_r <= {statSh_r[5:0], misoS2_r};
                  end
                  if (inData) begin
                     dataSh_r <= {dataSh_r[6:0], misoS2_r};
                  end
                  txSh_r <= {txSh_r[14:0], 1'b0};
                  mosi_r <= txSh_r[14];
                  if (lastEdge) begin
                     csN_r      <= 1'b1;
                     mosi_r     <= 1'b0;
                     spaceCnt_r <= 2'h0;
                     state_r    <= HS_SPACE;
                  end
               end
            end
            HS_SPACE: begin
               // let the device core absorb the frame
               if (fallNow) begin
                  spaceCnt_r <= 2'(spaceCnt_r + 1'b1);
                  if (spaceCnt_r == END_SPACE) begin
                     respValid_r <= 1'b1;
                     state_r     <= HS_IDLE;
                  end
               end
            end
            default: begin
               state_r <= HS_IDLE;
            end
         endcase
      end
   end
endmodule : rdfp_host
`default_nettype wire

// file: rtl/rdfp_device.sv
// device end: rx and tx byte fifos, link slave, thresholds, pin select
`timescale 1ns/1ns
`default_nettype none
module rdfp_device
   import rdfp_pkg::*;
(
   input  wire logic              clk,                  // core clock
   input  wire logic              rst,                  // sync reset
   rdfp_link_if.dev               link,                 // serial link
   input  wire logic [DATA_W-1:0] rxInData,             // radio byte in
   input  wire logic              rxInValid,            // radio byte valid
   output logic                   rxInReady,            // rx fifo room
   output logic [DATA_W-1:0]      txOutData,            // byte to radio
   output logic                   txOutValid,           // tx byte ready
   input  wire logic              txOutReady,           // radio takes byte
   input  wire logic [3:0]        fillThresholdSelect,  // threshold code
   input  wire logic [3:0]        outputPinSignalSelect,// 2 bits per pin
   output logic [1:0]             generalOutputPin,     // selected flags
   output logic [CNT_W-1:0]       rxFillCount,          // rx level
   output logic [CNT_W-1:0]       txFillCount,          // tx level
   output logic                   rxOverflow,           // sticky flag
   output logic                   txUnderflow,          // sticky flag
   output logic                   txOverflow,           // sticky flag
   input  wire logic              clearErrors           // clear flags
);
   ////////////////////////////////////////////////////////////////////////
   // core clock domain declarations
   logic [DATA_W-1:0] rxOutData;    // rx fifo head
   logic              rxOutValid;   // rx fifo not empty
   logic              txInReady;    // tx fifo not full
   logic              wrS1_r;       // write toggle sync first
   logic              wrS2_r;       // write toggle sync second
   logic              wrS3_r;       // write toggle edge history
   logic              rdS1_r;       // read toggle sync first
   logic              rdS2_r;       // read toggle sync second
   logic              rdS3_r;       // read toggle edge history
   logic              rdAck_r;      // read answer toggle
   logic [DATA_W-1:0] rdData_r;     // byte popped for the host
   logic [CNT_W-1:0]  rxGray_r;     // rx level, gray
   logic [CNT_W-1:0]  txGray_r;     // tx level, gray
   logic              rxOvf_r;      // rx overflow seen
   logic              txUnf_r;      // tx underflow seen
   logic              txOvf_r;      // tx overfill seen

   // link clock domain declarations
   logic              rstS1_r;      // reset sync first
   logic              rstS2_r;      // reset sync second
   logic [5:0]        bitCnt_r;     // edges taken in frame
   logic [7:0]        inSh_r;       // bits in from mosi
   logic [7:0]        outSh_r;      // bits out to miso
   logic              isRead_r;     // frame is a read
   logic              rdReq_r;      // read request toggle
   logic              wrReq_r;      // write request toggle
   logic [7:0]        wrByte_r;     // byte held for the core
   logic              ackS1_r;      // answer sync first
   logic              ackS2_r;      // answer sync second
   logic [CNT_W-1:0]  rxGS1_r;      // rx gray sync first
   logic [CNT_W-1:0]  rxGS2_r;      // rx gray sync second
   logic [CNT_W-1:0]  txGS1_r;      // tx gray sync first
   logic [CNT_W-1:0]  txGS2_r;      // tx gray sync second

   ////////////////////////////////////////////////////////////////////////
   // the two fifos
   wire wrPulse = wrS2_r ^ wrS3_r;  // host byte arrived
   wire rdPulse = rdS2_r ^ rdS3_r;  // host wants a byte

   rdfp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
      .clk      (clk),
      .rst      (rst),
      .inData   (rxInData),
      .inValid  (rxInValid),
      .inReady  (rxInReady),
      .outData  (rxOutData),
      .outValid (rxOutValid),
      .outReady (rdPulse),
      .count    (rxFillCount)
   );

   rdfp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) txFifo (
      .clk      (clk),
      .rst      (rst),
      .inData   (wrByte_r),
      .inValid  (wrPulse),
      .inReady  (txInReady),
      .outData  (txOutData),
      .outValid (txOutValid),
      .outReady (txOutReady),
      .count    (txFillCount)
   );

   ////////////////////////////////////////////////////////////////////////
   // thresholds and pin routing
   wire [CNT_W-1:0] selExt = {3'h0, fillThresholdSelect};
   wire [CNT_W-1:0] rxThr  = 7'(RX_THR_STEP * (selExt + 1'b1));
   wire [CNT_W-1:0] txThr  = 7'(TX_THR_BASE - RX_THR_STEP * selExt);
   wire rxThrFlag = rxFillCount >= rxThr;
   wire txThrFlag = txFillCount >= txThr;
   wire [3:0] pinSrc;                      // flags a pin may show

   assign pinSrc[PIN_RX_THR] = rxThrFlag;
   assign pinSrc[PIN_TX_THR] = txThrFlag;
   assign pinSrc[PIN_RX_OVF] = rxOvf_r;
   assign pinSrc[PIN_TX_UNF] = txUnf_r;

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : gPin
         // each pin picks one flag
         assign generalOutputPin[p] =
            pinSrc[outputPinSignalSelect[2*p +: 2]];
      end
   endgenerate

   assign rxOverflow  = rxOvf_r;
   assign txUnderflow = txUnf_r;
   assign txOverflow  = txOvf_r;

   ////////////////////////////////////////////////////////////////////////
   // error flags, a new event beats a clear
   always_ff @(posedge clk) begin
      if (rst) begin
         rxOvf_r <= 1'b0;
         txUnf_r <= 1'b0;
         txOvf_r <= 1'b0;
      end else begin
         rxOvf_r <= (rxInValid && !rxInReady) || (rxOvf_r && !clearErrors);
         txUnf_r <= (txOutReady && !txOutValid) || (txUnf_r && !clearErrors);
         txOvf_r <= (wrPulse && !txInReady) || (txOvf_r && !clearErrors);
      end
   end

   // request toggles in from the link domain
   always_ff @(posedge clk) begin
      if (rst) begin
         {wrS1_r, wrS2_r, wrS3_r} <= 3'h0;
         {rdS1_r, rdS2_r, rdS3_r} <= 3'h0;
      end else begin
         {wrS1_r, wrS2_r, wrS3_r} <= {wrReq_r, wrS1_r, wrS2_r};
         {rdS1_r, rdS2_r, rdS3_r} <= {rdReq_r, rdS1_r, rdS2_r};
      end
   end

   // pop for the host and answer; empty gives a stale byte
   always_ff @(posedge clk) begin
      if (rst) begin
         rdAck_r  <= 1'b0;
         rdData_r <= 8'h00;
      end else if (rdPulse) begin
         rdAck_r  <= !rdAck_r;
         rdData_r <= rxOutData;
      end
   end

   // fill levels leave the core as gray code
   always_ff @(posedge clk) begin
      if (rst) begin
         rxGray_r <= '0;
         txGray_r <= '0;
      end else begin
         rxGray_r <= rdfp_bin2gray(rxFillCount);
         txGray_r <= rdfp_bin2gray(txFillCount);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link domain: synchronisers
   always_ff @(posedge link.sclk) begin
      rstS1_r <= rst;
      rstS2_r <= rstS1_r;
      ackS1_r <= rdAck_r;
      ackS2_r <= ackS1_r;
      rxGS1_r <= rxGray_r;
      rxGS2_r <= rxGS1_r;
      txGS1_r <= txGray_r;
      txGS2_r <= txGS1_r;
   end

   // link decode
   wire [7:0] hdrByte = {inSh_r[6:0], link.mosi};   // byte ending now
   wire       hdrDone = bitCnt_r == 6'(HDR_LEN - 1'b1);
   wire       wrDone  = !isRead_r && bitCnt_r == 6'(WR_LEN - 1'b1);
   wire       rdDone  = isRead_r && bitCnt_r == 6'(RD_LEN - 1'b1);
   wire       rdLoad  = isRead_r && bitCnt_r == 6'(RD_LOAD - 1'b1);
   wire       stOnly  = hdrDone && hdrByte[HDR_ST_BIT];
   wire       frameEnd = stOnly || wrDone || rdDone;
   wire       ackOk   = ackS2_r == rdReq_r;  // core has answered
   wire [CNT_W-1:0] lvlSel = link.mosi ? rdfp_gray2bin(rxGS2_r)
                                       : rdfp_gray2bin(txGS2_r);

   assign link.miso = outSh_r[7];

   ////////////////////////////////////////////////////////////////////////
   // frame counter, inactive select ends a frame
   always_ff @(posedge link.sclk) begin
      if (rstS2_r || link.csN) begin
         bitCnt_r <= 6'h00;
      end else begin
         bitCnt_r <= frameEnd ? 6'h00 : 6'(bitCnt_r + 1'b1);
      end
   end

   // shift registers
   always_ff @(posedge link.sclk) begin
      if (rstS2_r || link.csN) begin
         inSh_r   <= 8'h00;
         outSh_r  <= 8'h00;
         isRead_r <= 1'b0;
      end else begin
         inSh_r <= hdrByte;
         if (bitCnt_r == 6'h00) begin
            isRead_r <= link.mosi;
            outSh_r  <= {lvlSel, 1'b0};
         end else if (rdLoad) begin
            outSh_r <= ackOk ? rdData_r : 8'h00;
         end else begin
            outSh_r <= {outSh_r[6:0], 1'b0};
         end
      end
   end

   // requests to the core, held until the next frame
   always_ff @(posedge link.sclk) begin
      if (rstS2_r) begin
         rdReq_r  <= 1'b0;
         wrReq_r  <= 1'b0;
         wrByte_r <= 8'h00;
      end else if (!link.csN) begin
         if (hdrDone && isRead_r && !hdrByte[HDR_ST_BIT]) begin
            rdReq_r <= !rdReq_r;
         end
         if (wrDone) begin
            wrByte_r <= hdrByte;
            wrReq_r  <= !wrReq_r;
         end
      end
   end
endmodule : rdfp_device
`default_nettype wire

// file: tb/rdfp_link_props.sv
// concurrent checks on link and device ports
`timescale 1ns/1ns
`default_nettype none
module rdfp_link_props
   import rdfp_pkg::*;
(
   input wire logic       clk, // core clock
   input wire logic       rst, // device reset
   input wire logic       sclk, // link clock
   input wire logic       csN, // frame select
   input wire logic       mosi, // host data
   input wire logic [3:0] fillThresholdSelect, // threshold code
   input wire logic [3:0] outputPinSignalSelect, // pin sources
   input wire logic [1:0] generalOutputPin, // pin levels
   input wire logic [6:0] rxFillCount, // rx level
   input wire logic [6:0] txFillCount, // tx level
   input wire logic       rxInValid, // radio push
   input wire logic       rxInReady, // rx room
   input wire logic       txOutValid, // tx not empty
   input wire logic       txOutReady, // radio pop
   input wire logic       rxOverflow, // rx flag
   input wire logic       txUnderflow, // tx flag
   input wire logic       clearErrors // flag clear
);
   ////////////////////////////////////////////////////////////////////////
   // expected thresholds
   wire [6:0] rxThr = {1'b0, fillThresholdSelect, 2'b00} + 7'h04;
   wire [6:0] txThr = 7'h3D - {1'b0, fillThresholdSelect, 2'b00};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   pin_rx_thr_a: assert property (
      outputPinSignalSelect[1:0] == PIN_RX_THR |->
      generalOutputPin[0] == (rxFillCount >= rxThr)) else $error("rx pin");
   pin_tx_thr_a: assert property (
      outputPinSignalSelect[3:2] == PIN_TX_THR |->
      generalOutputPin[1] == (txFillCount >= txThr)) else $error("tx pin");
   pin_ovf_a: assert property (
      outputPinSignalSelect[3:2] == PIN_RX_OVF |->
      generalOutputPin[1] == rxOverflow) else $error("ovf pin");
   rx_ovf_set_a: assert property (rxInValid && !rxInReady |=> rxOverflow)
      else $error("no overflow flag");
   tx_unf_set_a: assert property (
      txOutReady && !txOutValid |=> txUnderflow) else $error("no underflow");
   ovf_hold_a: assert property (
      rxOverflow && !clearErrors |=> rxOverflow) else $error("overflow lost");
   rx_full_a: assert property (rxFillCount == 7'h40 |-> !rxInReady)
      else $error("full rx accepts");
   cnt_bound_a: assert property (
      rxFillCount <= 7'h40 && txFillCount <= 7'h40) else $error("past depth");
   rx_grow_a: assert property ($past(rxFillCount) < rxFillCount |->
      $past(rxInValid && rxInReady) || $past(rxInValid && rxInReady, 2))
      else $error("rx grew without push");
   link_setup_a: assert property (
      $rose(sclk) |-> $stable(mosi) && $stable(csN)) else $error("link moved");
endmodule : rdfp_link_props
`default_nettype wire

// file: tb/tb.sv
// self-checking bench joining host and device ends
`timescale 1ns/1ns
`default_nettype none
module tb
   import rdfp_pkg::*;
;
   logic       clk, rst, rstDev, cmdValid, cmdRead, cmdStatusOnly; // drives
   logic       rxInValid, txOutReady, clearErrors; // drives
   logic [7:0] cmdData, rxInData; // bytes
   logic [3:0] fillThresholdSelect, outputPinSignalSelect; // setup
   wire        cmdReady, respValid, rxInReady, txOutValid; // status
   wire        rxOverflow, txUnderflow, txOverflow; // flags
   wire  [7:0] respStatus, respData, txOutData; // bytes
   wire  [1:0] generalOutputPin; // pins
   wire  [6:0] rxFillCount, txFillCount; // levels
   int         fail_count, compares; // tallies
   ////////////////////////////////////////////////////////////////////////
   rdfp_link_if rdfp_link_if_i ();
   rdfp_host rdfp_host_i (.clk, .rst, .link(rdfp_link_if_i), .cmdValid,
      .cmdReady, .cmdRead, .cmdStatusOnly, .cmdData, .respValid, .respStatus,
      .respData);
   rdfp_device rdfp_device_i (.clk, .rst(rstDev), .link(rdfp_link_if_i),
      .rxInData, .rxInValid, .rxInReady, .txOutData, .txOutValid, .txOutReady,
      .fillThresholdSelect, .outputPinSignalSelect, .generalOutputPin,
      .rxFillCount, .txFillCount, .rxOverflow, .txUnderflow, .txOverflow,
      .clearErrors);
   rdfp_link_props rdfp_link_props_i (.clk, .rst(rstDev),
      .sclk(rdfp_link_if_i.sclk), .csN(rdfp_link_if_i.csN),
      .mosi(rdfp_link_if_i.mosi), .fillThresholdSelect, .outputPinSignalSelect,
      .generalOutputPin, .rxFillCount, .txFillCount, .rxInValid, .rxInReady,
      .txOutValid, .txOutReady, .rxOverflow, .txUnderflow, .clearErrors);
   ////////////////////////////////////////////////////////////////////////
   // tally one comparison
   task automatic chk(input bit ok, input string m);
      compares++;
      if (!ok) begin
         fail_count++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask : chk
   // one host access, then wait for the answer; a hang meets the watchdog
   task automatic host_cmd(input logic rd, st, input logic [7:0] d);
      @(posedge clk) #1;
      {cmdValid, cmdRead, cmdStatusOnly, cmdData} = {1'b1, rd, st, d};
      do @(negedge clk); while (cmdReady !== 1'b1);
      @(posedge clk) #1 cmdValid = 1'b0;
      do @(negedge clk); while (respValid !== 1'b1);
   endtask : host_cmd
   // sweep threshold codes at one level
   task automatic thr_chk(input bit tx, input int lvl);
      for (int v = 0; v < 16; v++) begin
         @(posedge clk) #1 fillThresholdSelect = 4'(v);
         @(negedge clk);
         if (tx) chk(generalOutputPin[1] === (lvl >= 61-4*v), "tx");
         else chk(generalOutputPin[0] === (lvl >= 4*v+4), "rx");
      end
   endtask : thr_chk
   // pulse the flag clear
   task automatic clear_flags();
      @(posedge clk) #1 clearErrors = 1'b1;
      @(posedge clk) #1 clearErrors = 1'b0;
      @(negedge clk);
      chk({rxOverflow, txUnderflow, txOverflow} === 3'h0, "flags stuck");
   endtask : clear_flags
   ////////////////////////////////////////////////////////////////////////
   // radio fills rx until refused
   task automatic test_rx_fill();
      for (int i = 0; i < 64; i++) begin
         @(posedge clk) #1 {rxInValid, rxInData} = {1'b1, 8'hA0 ^ 8'(i)};
         @(posedge clk) #1 rxInValid = 1'b0;
         @(negedge clk);
         chk(rxFillCount === 7'(i + 1), "rx level");
         thr_chk(1'b0, i + 1);
      end
      chk(rxInReady === 1'b0, "rx not full");
      @(posedge clk) #1 rxInValid = 1'b1;
      @(posedge clk) #1 rxInValid = 1'b0;
      outputPinSignalSelect = {PIN_RX_OVF, PIN_RX_THR};
      @(negedge clk);
      chk({rxOverflow, generalOutputPin[1]} === 2'h3, "no ovf");
      clear_flags();
      @(posedge clk) #1 outputPinSignalSelect = {PIN_TX_THR, PIN_RX_THR};
      $display("rx fill done");
   endtask : test_rx_fill
   // host drains rx, status shows rx level
   task automatic test_rx_read();
      host_cmd(1'b1, 1'b1, 8'h00);
      chk(respStatus === 8'h40, "rx poll");
      for (int i = 0; i < 64; i++) begin
         host_cmd(1'b1, 1'b0, 8'h00);
         chk(respData === (8'hA0 ^ 8'(i)), "rx byte");
         chk(respStatus === 8'(64 - i), "rx status");
      end
      chk(rxFillCount === 7'h00, "rx not empty");
      $display("rx read done");
   endtask : test_rx_read
   // host fills tx, radio drains it past empty
   task automatic test_tx();
      for (int i = 0; i < 64; i++) begin
         host_cmd(1'b0, 1'b0, 8'h5A ^ 8'(i));
         chk(respStatus === 8'(i), "tx status");
         chk(txFillCount === 7'(i + 1), "tx level");
         thr_chk(1'b1, i + 1);
      end
      @(posedge clk) #1 outputPinSignalSelect = {PIN_TX_UNF, PIN_RX_THR};
      for (int i = 0; i < 65; i++) begin
         @(negedge clk);
         if (i < 64)
            chk({txOutValid, txOutData} === {1'b1, 8'h5A ^ 8'(i)}, "tx");
         @(posedge clk) #1 txOutReady = 1'b1;
         @(posedge clk) #1 txOutReady = 1'b0;
      end
      @(negedge clk);
      chk({txUnderflow, generalOutputPin[1]} === 2'h3, "no unf");
      clear_flags();
      $display("tx done");
   endtask : test_tx
   // counts and verdict, then stop
   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////
   // clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #1000000;
      fail_count++;
      $display("FAIL %0t watchdog expired", $time);
      print_verdict();
   end
   initial begin
      {rst, rstDev, cmdValid, cmdRead, cmdStatusOnly} = 5'h18;
      {rxInValid, txOutReady, clearErrors, rxInData, cmdData} = 19'h00000;
      fillThresholdSelect = 4'h0;
      outputPinSignalSelect = {PIN_TX_THR, PIN_RX_THR};
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      repeat (32) @(posedge clk);
      #1 rstDev = 1'b0;
      repeat (16) @(posedge clk);
      test_rx_fill();
      test_rx_read();
      test_tx();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
